// >>> rtl/bls_pwm_timeouts.sv
// Per-sink PWM scaling select and backlight dim/off timeout sequencer.
`timescale 1ns/100ps
// Summary of operation
// - Seven enable bits let PWM scale sinks.
// - Cleared bit passes sink current unscaled.
// - Off timeout 1..127 s, zero disables.
// - Off countdown starts after dim expires, or at maximum current with dim disabled.
// - Dim timeout 1..127 s sets dim current.
// - Dim countdown starts at maximum current.
// - Unselected sinks follow common backlight enable.
module bls_pwm_timeouts
  import bls_pkg::*;
#(
  // Clock cycles per one-second tick; a bench may shorten it.
  parameter logic [25:0] TICK_LEN = TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic                  REF_CLK,
  input  wire logic                  RESET_N,
  // Register access from the serial interface core.
  input  wire bls_pkg::bls_wr_s      REG_WR,
  input  wire logic [7:0]            REG_RD_ADDR,
  output logic      [7:0]            REG_RD_DATA,
  // Backlight status and sink inputs.
  input  wire logic                  PWM_IN,
  input  wire logic                  BL_AT_MAX,
  input  wire logic                  BL_RESTART,
  input  wire logic [6:0]            SINK_INDEP_SEL,
  input  wire logic [6:0]            SINK_ON_IN,
  // Sink gating and backlight commands.
  output logic      [6:0]            SINK_DRIVE,
  output logic                       BL_DIM,
  output logic                       GROUP_LIGHT_ENABLE
);
  import bls_pkg::*;

  typedef struct packed {
    logic [6:0]  pwm_sel;
    logic [6:0]  off_delay_seconds;
    logic [6:0]  dim_delay_seconds;
    logic [25:0] tick_cnt;
    logic [6:0]  cnt;
    bls_state_e  state;
    logic        dim;
    logic        en;
    logic [6:0]  drive;
    logic [7:0]  rd;
  } bls_state_s;

  bls_state_s st_ff;
  bls_state_s nxt_st;
  logic       tick;
  logic [6:0] sink_lit;

  // Combinational next state.
  always_comb
  begin
    nxt_st = st_ff;
    tick   = 1'b0;
    sink_lit = '0;
    if (REG_WR.wr)
    begin
      unique case (REG_WR.addr)
        PWM_SEL_OFFSET: nxt_st.pwm_sel = REG_WR.data[6:0];
        OFF_TMO_OFFSET: nxt_st.off_delay_seconds = REG_WR.data[6:0];
        DIM_TMO_OFFSET: nxt_st.dim_delay_seconds = REG_WR.data[6:0];
        default: ;
      endcase
    end
    // One-second tick runs only while a countdown is active.
    if (st_ff.state inside {ST_DIM, ST_OFF})
    begin
      if (st_ff.tick_cnt == TICK_LEN - 26'd1)
      begin
        nxt_st.tick_cnt = '0;
        tick = 1'b1;
      end
      else
        nxt_st.tick_cnt = st_ff.tick_cnt + 26'd1;
    end
    else
      nxt_st.tick_cnt = '0;
    unique case (st_ff.state)
      ST_IDLE:
      begin
        nxt_st.en  = 1'b1;
        nxt_st.dim = 1'b0;
        if (BL_AT_MAX)
        begin
          if (st_ff.dim_delay_seconds != TMO_DISABLED)
          begin
            nxt_st.state = ST_DIM;
            nxt_st.cnt   = st_ff.dim_delay_seconds;
          end
          else if (st_ff.off_delay_seconds != TMO_DISABLED)
          begin
            nxt_st.state = ST_OFF;
            nxt_st.cnt   = st_ff.off_delay_seconds;
          end
        end
      end
      ST_DIM:
        if (tick)
        begin
          if (st_ff.cnt == 7'd1)
          begin
            nxt_st.dim = 1'b1;
            if (st_ff.off_delay_seconds != TMO_DISABLED)
            begin
              nxt_st.state = ST_OFF;
              nxt_st.cnt   = st_ff.off_delay_seconds;
            end
            else
              nxt_st.state = ST_DONE;
          end
          else
            nxt_st.cnt = st_ff.cnt - 7'd1;
        end
      ST_OFF:
        if (tick)
        begin
          if (st_ff.cnt == 7'd1)
          begin
            nxt_st.en    = 1'b0;
            nxt_st.state = ST_DONE;
          end
          else
            nxt_st.cnt = st_ff.cnt - 7'd1;
        end
      ST_DONE: ;
      default: nxt_st.state = ST_IDLE;
    endcase
    // Restart of the sequence wakes the backlight.
    if (BL_RESTART)
    begin
      nxt_st.state = ST_IDLE;
      nxt_st.en    = 1'b1;
      nxt_st.dim   = 1'b0;
      nxt_st.cnt   = '0;
    end
    // Grouped sinks follow the common enable, others their own.
    for (int i = 0; i < NUM_SINKS; i++)
    begin
      sink_lit[i] = SINK_INDEP_SEL[i] ? SINK_ON_IN[i] : st_ff.en;
      if (st_ff.pwm_sel[i])
        nxt_st.drive[i] = sink_lit[i] & PWM_IN;
      else
        nxt_st.drive[i] = sink_lit[i];
    end
    // Register read mux, reserved bit reads zero.
    unique case (REG_RD_ADDR)
      PWM_SEL_OFFSET: nxt_st.rd = {1'b0, st_ff.pwm_sel};
      OFF_TMO_OFFSET: nxt_st.rd = {1'b0, st_ff.off_delay_seconds};
      DIM_TMO_OFFSET: nxt_st.rd = {1'b0, st_ff.dim_delay_seconds};
      default:        nxt_st.rd = 8'h00;
    endcase
  end

  // State register.
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_ff.pwm_sel           <= PWM_SEL_RESET;
      st_ff.off_delay_seconds <= TMO_RESET;
      st_ff.dim_delay_seconds <= TMO_RESET;
      st_ff.tick_cnt          <= '0;
      st_ff.cnt               <= '0;
      st_ff.state             <= ST_IDLE;
      st_ff.dim               <= 1'b0;
      st_ff.en                <= 1'b1;
      st_ff.drive             <= '0;
      st_ff.rd                <= 8'h00;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs come straight from the state register.
  assign REG_RD_DATA        = st_ff.rd;
  assign SINK_DRIVE         = st_ff.drive;
  assign BL_DIM             = st_ff.dim;
  assign GROUP_LIGHT_ENABLE = st_ff.en;

  // Off comes only from the off countdown.
  off_after_off_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    $fell(st_ff.en) |-> $past(st_ff.state) == ST_OFF
      && !$past(BL_RESTART))
    else $error("backlight off outside off countdown");
  // Dim asserts only on the last dim tick.
  dim_on_tick_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    $rose(st_ff.dim) |-> $past(st_ff.state) == ST_DIM
      && $past(st_ff.cnt) == 7'd1 && $past(tick))
    else $error("dim set without dim expiry");
  // Off countdown follows dim when dim is enabled.
  off_after_dim_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (st_ff.state == ST_OFF && $past(st_ff.state) == ST_IDLE)
      |-> $past(st_ff.dim_delay_seconds) == TMO_DISABLED)
    else $error("off countdown started before dim");
  // Dim countdown starts only at maximum current.
  dim_start_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (st_ff.state == ST_DIM && $past(st_ff.state) == ST_IDLE)
      |-> $past(BL_AT_MAX))
    else $error("dim countdown without maximum current");
  // Ticks are at least nine cycles apart.
  tick_gap_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    tick |=> !tick [*8])
    else $error("tick too soon");
  // Unscaled sinks ignore the PWM input.
  pwm_ignore_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !st_ff.pwm_sel[0] && !SINK_INDEP_SEL[0] |=> SINK_DRIVE[0]
      == $past(st_ff.en))
    else $error("unscaled sink followed pwm");
  // Scaled sinks are gated by the PWM input.
  pwm_scale_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    st_ff.pwm_sel[0] && !PWM_IN |=> !SINK_DRIVE[0])
    else $error("scaled sink lit with pwm low");
  // Grouped sinks drop with the common enable.
  group_off_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !SINK_INDEP_SEL[1] && !st_ff.en |=> !SINK_DRIVE[1])
    else $error("grouped sink lit while backlight off");

endmodule

// >>> rtl/bls_pkg.sv
// Package with register map, field layout and timing constants for the block.
package bls_pkg;

  // Register offsets on the internal register port.
  localparam logic [7:0] PWM_SEL_OFFSET = 8'h06;
  localparam logic [7:0] OFF_TMO_OFFSET = 8'h07;
  localparam logic [7:0] DIM_TMO_OFFSET = 8'h08;

  // Field layout and reset values.
  localparam int         NUM_SINKS      = 7;
  localparam int         TMO_WIDTH      = 7;
  localparam logic [6:0] PWM_SEL_RESET  = 7'h00;
  localparam logic [6:0] TMO_RESET      = 7'h00;
  localparam logic [6:0] TMO_DISABLED   = 7'h00;

  // Timing of the one-second tick.
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          TICK_SECONDS  = 1;
  localparam logic [25:0] TICK_CYCLES   = 26'(CLK_HZ * TICK_SECONDS);

  // Register write request from the serial interface core.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } bls_wr_s;

  // Timing sequence states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DIM  = 4'b0010,
    ST_OFF  = 4'b0100,
    ST_DONE = 4'b1000
  } bls_state_e;

endpackage

// >>> dv/bls_pwm_src.sv
// Behavioural external PWM source that drives the block's PWM input.
`timescale 1ns/100ps
module bls_pwm_src
(
  // Clock and level control.
  input  wire logic clk,
  input  wire logic run,
  input  wire logic lvl,
  // PWM level to the block.
  output logic      pwm
);
  // Toggles each falling edge while running, else takes the set level.
  always @(negedge clk)
  begin
    pwm <= run ? ~pwm : lvl;
  end
  initial pwm = 1'b0;
endmodule

// >>> dv/bls_pwm_timeouts_tb.sv
// Self-checking bench for the PWM select and timeout block.
`timescale 1ns/100ps
module bls_pwm_timeouts_tb;
  import bls_pkg::*;
  logic       ref_clk, reset_n, pwm_in, at_max, restart, run, lvl;
  logic       bl_dim, group_en;
  logic [7:0] rd_addr, rd_data;
  logic [6:0] indep, sink_on, sink_drive, v;
  bls_wr_s    reg_wr;
  int         mismatches, compares;
  // Short one-second tick so that timeouts fit in the run.
  localparam int TK = 20;

  bls_pwm_timeouts #(.TICK_LEN(26'(TK))) DUT (.REF_CLK(ref_clk),
    .RESET_N(reset_n),
    .REG_WR(reg_wr), .REG_RD_ADDR(rd_addr), .REG_RD_DATA(rd_data),
    .PWM_IN(pwm_in), .BL_AT_MAX(at_max), .BL_RESTART(restart),
    .SINK_INDEP_SEL(indep), .SINK_ON_IN(sink_on),
    .SINK_DRIVE(sink_drive), .BL_DIM(bl_dim),
    .GROUP_LIGHT_ENABLE(group_en));
  bls_pwm_src src (.clk(ref_clk), .run(run), .lvl(lvl), .pwm(pwm_in));

  // The 40 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Compares a seen value with the expected one.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Holds restart over two edges to restart the timing sequence.
  task automatic pulse_restart();
    restart = 1'b1;
    step(2);
    restart = 1'b0;
  endtask
  // Single-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = '{1'b1, a, d};
    @(negedge ref_clk);
    reg_wr.wr = 1'b0;
  endtask
  // Read data is registered one cycle after the address.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    rd_addr = a;
    step(1);
    check(rd_data, exp);
  endtask
  // Sets sink inputs and PWM level, then checks the registered gate.
  task automatic sink(input logic [6:0] s, on, input logic l,
                      input logic [6:0] exp);
    @(negedge ref_clk);
    indep = s;
    sink_on = on;
    lvl <= l;
    step(2);
    check({1'b0, sink_drive}, {1'b0, exp});
  endtask
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    mismatches = 0;
    compares = 0;
    reset_n = 1'b0;
    reg_wr = '0;
    rd_addr = 8'h00;
    at_max = 1'b0;
    restart = 1'b0;
    run = 1'b0;
    lvl = 1'b0;
    indep = 7'h00;
    sink_on = 7'h00;
    step(20);
    reset_n = 1'b1;
    rdchk(8'h06, 8'h00);
    rdchk(8'h07, 8'h00);
    rdchk(8'h08, 8'h00);
    wr(8'h06, 8'hFF);
    wr(8'h07, 8'h81);
    wr(8'h08, 8'h82);
    wr(8'h05, 8'h33);
    rdchk(8'h06, 8'h7F);
    rdchk(8'h07, 8'h01);
    rdchk(8'h08, 8'h02);
    rdchk(8'h05, 8'h00);
    $display("Test registers done");
    wr(8'h06, 8'h55);
    sink(7'h00, 7'h00, 1'b0, 7'h2A);
    sink(7'h00, 7'h00, 1'b1, 7'h7F);
    sink(7'h7F, 7'h0F, 1'b0, 7'h0A);
    sink(7'h70, 7'h00, 1'b1, 7'h0F);
    // A PWM input toggling every cycle flips only the scaled sinks.
    indep = 7'h00;
    run <= 1'b1;
    step(3);
    v = sink_drive;
    step(1);
    check({1'b0, sink_drive ^ v}, 8'h55);
    run <= 1'b0;
    $display("Test sinks done");
    wr(8'h07, 8'h00);
    wr(8'h08, 8'h00);
    at_max = 1'b1;
    step(50);
    check({7'h00, bl_dim}, 8'h00);
    check({7'h00, group_en}, 8'h01);
    // Dim two ticks after maximum current, then off one tick later.
    at_max = 1'b0;
    wr(8'h08, 8'h02);
    wr(8'h07, 8'h01);
    pulse_restart();
    step(TK * 3);
    check({7'h00, bl_dim}, 8'h00);
    at_max = 1'b1;
    step(TK * 2 - 2);
    check({7'h00, bl_dim}, 8'h00);
    step(4);
    check({7'h00, bl_dim}, 8'h01);
    step(TK - 3);
    check({7'h00, group_en}, 8'h01);
    step(4);
    check({7'h00, group_en}, 8'h00);
    check({7'h00, bl_dim}, 8'h01);
    // With dim disabled the off countdown starts at once.
    wr(8'h08, 8'h00);
    pulse_restart();
    step(TK - 2);
    check({7'h00, group_en}, 8'h01);
    check({7'h00, bl_dim}, 8'h00);
    step(5);
    check({7'h00, group_en}, 8'h00);
    $display("Test timers done");
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    rdchk(8'h06, 8'h00);
    check({7'h00, group_en}, 8'h01);
    check({7'h00, bl_dim}, 8'h00);
    $display("Test reset done");
    print_verdict();
  end
endmodule
